//--- hdl/dtc_timer.sv
/*
 * Dual timer/counter with four modes (13-bit, 16-bit, 8-bit auto-reload,
 * split), prescaled or pin-edge counting and gate inputs.
 * Assumes count pins and gate inputs synchronous to clk, and a register
 * master that never issues read and write strobes together.
 */
// How it works
// RULE1: Timer function counts each tick: every clock or every twelfth clock.
// RULE2: Counter function counts each falling edge on the count pin.
// RULE3: Pin source must hold each level two clocks; quarter clock max.
// RULE4: Each count is 16 bits, accessed as low and high bytes.
// RULE5: Each timer has own mode, source, gate and run controls.
// RULE6: Mode 0 is 13 bits: high byte plus low bits 4..0.
// RULE7: Mode 0 wrap from 0x1FFF to zero sets overflow flag.
// RULE8: Source select clear counts ticks; set counts pin falling edges.
// RULE9: Count only when run and (gate disabled or gate input high).
// RULE10: Setting run neither clears nor loads the count.
// RULE11: Mode 1 counts all 16 bits, flag on wrap to zero.
// RULE12: Mode 2 low byte counts; wrap sets flag and reloads from high.
// RULE13: Software preloads low byte before running mode 2.
// RULE14: Mode 3 timer_a low byte uses timer_a controls and flag.
// RULE15: Mode 3 timer_a high byte ticks on timer_b run, sets b flag.
// RULE16: Timer_b in mode 3 holds its count.
// RULE17: With timer_a split, timer_b ticks only, no flag, pulse still out.
// RULE18: Timer_b implements modes 0, 1, 2 like timer_a.
// RULE19: Mode codes: 00 13-bit, 01 16-bit, 10 reload, 11 split/stop.
// RULE20: Overflow flags clear by software write or interrupt acknowledge.
// RULE21: Tick select 0 divides by twelve, 1 uses the clock directly.
// RULE22: Count pins compared across two samples for single-cycle edges.
`timescale 1ns/1ps
`default_nettype none

module dtc_timer
(
	input  wire logic       clk,             // System clock
	input  wire logic       rst_n,           // Synchronous reset, active low
	input  wire logic [2:0] reg_addr,        // Register address
	input  wire logic [7:0] reg_wdata,       // Write data
	input  wire logic       reg_wr,          // Write strobe
	input  wire logic       reg_rd,          // Read strobe
	output logic      [7:0] reg_rdata,       // Read data, cycle after strobe
	input  wire logic       count_pin_a,     // Timer_a event input
	input  wire logic       count_pin_b,     // Timer_b event input
	input  wire logic       gate_input_a_n,  // Timer_a gate level
	input  wire logic       gate_input_b_n,  // Timer_b gate level
	input  wire logic       int_ack_a,       // Interrupt vectored, timer_a
	input  wire logic       int_ack_b,       // Interrupt vectored, timer_b
	output logic            irq_a,           // Timer_a overflow flag
	output logic            irq_b,           // Timer_b overflow flag
	output logic            overflow_b_pulse // Timer_b overflow, baud use
);

	// ********************************
	// Registers
	// ********************************
	logic [7:0] timer_a_low_byte;
	logic [7:0] timer_a_high_byte;
	logic [7:0] timer_b_low_byte;
	logic [7:0] timer_b_high_byte;
	logic [7:0] timer_mode_reg;
	logic [7:0] tick_select_reg;
	logic       timer_a_run;
	logic       timer_b_run;
	logic       timer_a_overflow_flag;
	logic       timer_b_overflow_flag;

	logic [3:0] prescale;
	logic       tick12;
	logic [1:0] pin_a_hist;
	logic [1:0] pin_b_hist;
	logic       fall_a;
	logic       fall_b;

	function automatic logic is_wr(input logic [2:0] a, input logic [2:0] target);
		is_wr = reg_wr && (a == target);
	endfunction

	// ********************************
	// Field decode
	// ********************************
	dtc_pkg::dtc_mode_t mode_a;
	dtc_pkg::dtc_mode_t mode_b;
	logic               timer_a_gate_enable;
	logic               timer_b_gate_enable;
	logic               timer_a_source_select;
	logic               timer_b_source_select;
	logic               timer_a_tick_select;
	logic               timer_b_tick_select;
	logic               timer_c_tick_select;

	assign mode_a = dtc_pkg::dtc_mode_t'(timer_mode_reg[dtc_pkg::FLD_MODE_HI:dtc_pkg::FLD_MODE_LO]); // RULE5
	assign mode_b = dtc_pkg::dtc_mode_t'(timer_mode_reg[dtc_pkg::MODE_B_BASE + dtc_pkg::FLD_MODE_HI
		-: 2]); // RULE5
	assign timer_a_gate_enable   = timer_mode_reg[dtc_pkg::FLD_GATE];
	assign timer_b_gate_enable   = timer_mode_reg[dtc_pkg::MODE_B_BASE + dtc_pkg::FLD_GATE];
	assign timer_a_source_select = timer_mode_reg[dtc_pkg::FLD_SOURCE];
	assign timer_b_source_select = timer_mode_reg[dtc_pkg::MODE_B_BASE + dtc_pkg::FLD_SOURCE];
	assign timer_a_tick_select   = tick_select_reg[dtc_pkg::BIT_A_TICK];
	assign timer_b_tick_select   = tick_select_reg[dtc_pkg::BIT_B_TICK];
	assign timer_c_tick_select   = tick_select_reg[dtc_pkg::BIT_C_TICK];

	// ********************************
	// Prescaler and pin edges
	// ********************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prescale <= dtc_pkg::PRESCALE_ZERO;
		else if (prescale == dtc_pkg::PRESCALE_LAST)
			prescale <= dtc_pkg::PRESCALE_ZERO;
		else
			prescale <= prescale + 4'h1;
	end
	assign tick12 = (prescale == dtc_pkg::PRESCALE_LAST); // RULE21

	// Pins are synchronous; two samples spot the fall
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_a_hist <= 2'h3;
			pin_b_hist <= 2'h3;
		end
		else
		begin
			pin_a_hist <= {pin_a_hist[0], count_pin_a}; // RULE22
			pin_b_hist <= {pin_b_hist[0], count_pin_b}; // RULE22
		end
	end
	assign fall_a = pin_a_hist[1] && !pin_a_hist[0]; // RULE2 RULE3
	assign fall_b = pin_b_hist[1] && !pin_b_hist[0]; // RULE2

	// ********************************
	// Count enables
	// ********************************
	logic tick_a;
	logic tick_b;
	logic split;
	logic run_a;
	logic run_b;
	logic inc_a;
	logic inc_b;
	logic inc_ah;

	assign split  = (mode_a == dtc_pkg::DTC_MODE_SPLIT); // RULE19
	assign tick_a = timer_a_tick_select ? 1'b1 : tick12; // RULE1 RULE21
	assign tick_b = timer_b_tick_select ? 1'b1 : tick12; // RULE1 RULE21
	assign run_a  = timer_a_run && (!timer_a_gate_enable || gate_input_a_n); // RULE9
	assign run_b  = timer_b_run && (!timer_b_gate_enable || gate_input_b_n); // RULE9
	assign inc_a  = run_a && (timer_a_source_select ? fall_a : tick_a); // RULE8 RULE14
	// Timer_b loses its run bit and flag to timer_a's high byte in split
	assign inc_b  = (mode_b != dtc_pkg::DTC_MODE_SPLIT) // RULE16
		&& (split ? tick_b // RULE17
		: (run_b && (timer_b_source_select ? fall_b : tick_b))); // RULE8 RULE18
	assign inc_ah = split && timer_b_run && tick_a; // RULE15

	// ********************************
	// Per-timer next state and overflow
	// ********************************
	logic [7:0]  next_a_low;
	logic [7:0]  next_a_high;
	logic        ovf_a;
	logic        ovf_ah;
	logic [7:0]  next_b_low;
	logic [7:0]  next_b_high;
	logic        ovf_b;
	logic [16:0] step_a;
	logic [16:0] step_b;

	// One count step on a low/high pair, as {overflow, high, low}
	function automatic logic [16:0] count_step(input dtc_pkg::dtc_mode_t m, input logic [7:0] lo,
		input logic [7:0] hi);
		logic [16:0] r;
		r = {1'b0, hi, lo + 8'h01};
		unique case (m)
			dtc_pkg::DTC_MODE_13BIT:
			begin
				if (lo[4:0] == dtc_pkg::LOW5_ONES) // RULE6 RULE7
					r = {hi == dtc_pkg::BYTE_ONES, hi + 8'h01, lo[7:5], 5'h00};
			end
			dtc_pkg::DTC_MODE_16BIT:
			begin
				if (lo == dtc_pkg::BYTE_ONES) // RULE4 RULE11
					r = {hi == dtc_pkg::BYTE_ONES, hi + 8'h01, lo + 8'h01};
			end
			dtc_pkg::DTC_MODE_RELOAD:
			begin
				if (lo == dtc_pkg::BYTE_ONES) // RULE12 RULE13
					r = {1'b1, hi, hi};
			end
			dtc_pkg::DTC_MODE_SPLIT:
				r = {lo == dtc_pkg::BYTE_ONES, hi, lo + 8'h01}; // RULE14
		endcase
		return r;
	endfunction

	always_comb
	begin
		step_a      = count_step(mode_a, timer_a_low_byte, timer_a_high_byte);
		next_a_low  = timer_a_low_byte;
		next_a_high = timer_a_high_byte;
		ovf_a       = 1'b0;
		ovf_ah      = 1'b0;
		if (inc_a)
		begin
			next_a_low  = step_a[7:0];
			next_a_high = step_a[15:8];
			ovf_a       = step_a[16];
		end
		if (inc_ah)
		begin
			next_a_high = timer_a_high_byte + 8'h01; // RULE15
			ovf_ah      = (timer_a_high_byte == dtc_pkg::BYTE_ONES);
		end
	end

	// Timer_b in its own mode 3 never gets inc_b, so it holds
	always_comb
	begin
		step_b      = count_step(mode_b, timer_b_low_byte, timer_b_high_byte);
		next_b_low  = timer_b_low_byte;
		next_b_high = timer_b_high_byte;
		ovf_b       = 1'b0;
		if (inc_b) // RULE18 RULE16
		begin
			next_b_low  = step_b[7:0];
			next_b_high = step_b[15:8];
			ovf_b       = step_b[16];
		end
	end

	// ********************************
	// Count registers (software write wins over counting)
	// ********************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_a_low_byte  <= dtc_pkg::RESET_BYTE;
			timer_a_high_byte <= dtc_pkg::RESET_BYTE;
			timer_b_low_byte  <= dtc_pkg::RESET_BYTE;
			timer_b_high_byte <= dtc_pkg::RESET_BYTE;
		end
		else
		begin
			timer_a_low_byte  <= is_wr(reg_addr, dtc_pkg::ADDR_A_LOW)  ? reg_wdata : next_a_low;
			timer_a_high_byte <= is_wr(reg_addr, dtc_pkg::ADDR_A_HIGH) ? reg_wdata : next_a_high;
			timer_b_low_byte  <= is_wr(reg_addr, dtc_pkg::ADDR_B_LOW)  ? reg_wdata : next_b_low;
			timer_b_high_byte <= is_wr(reg_addr, dtc_pkg::ADDR_B_HIGH) ? reg_wdata : next_b_high;
		end
	end

	// ********************************
	// Configuration registers
	// ********************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_mode_reg  <= dtc_pkg::RESET_BYTE;
			tick_select_reg <= dtc_pkg::RESET_BYTE;
			timer_a_run     <= 1'b0;
			timer_b_run     <= 1'b0;
		end
		else
		begin
			if (is_wr(reg_addr, dtc_pkg::ADDR_MODE))
				timer_mode_reg <= reg_wdata;
			if (is_wr(reg_addr, dtc_pkg::ADDR_TICK_SELECT))
				tick_select_reg <= reg_wdata & dtc_pkg::TICK_SELECT_MASK;
			if (is_wr(reg_addr, dtc_pkg::ADDR_CONTROL_STATUS))
			begin
				timer_a_run <= reg_wdata[dtc_pkg::BIT_A_RUN]; // RULE10
				timer_b_run <= reg_wdata[dtc_pkg::BIT_B_RUN]; // RULE10
			end
		end
	end

	// ********************************
	// Overflow flags: set beats clear
	// ********************************
	logic set_a;
	logic set_b;
	logic clr_a;
	logic clr_b;

	assign set_a = ovf_a;
	assign set_b = ovf_ah || (ovf_b && !split); // RULE15 RULE17
	assign clr_a = int_ack_a || (is_wr(reg_addr, dtc_pkg::ADDR_CONTROL_STATUS)
		&& !reg_wdata[dtc_pkg::BIT_A_FLAG]); // RULE20
	assign clr_b = int_ack_b || (is_wr(reg_addr, dtc_pkg::ADDR_CONTROL_STATUS)
		&& !reg_wdata[dtc_pkg::BIT_B_FLAG]); // RULE20

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_a_overflow_flag <= 1'b0;
			timer_b_overflow_flag <= 1'b0;
		end
		else
		begin
			timer_a_overflow_flag <= set_a || (timer_a_overflow_flag && !clr_a); // RULE7 RULE20
			timer_b_overflow_flag <= set_b || (timer_b_overflow_flag && !clr_b); // RULE20
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			overflow_b_pulse <= 1'b0;
		else
			overflow_b_pulse <= ovf_b; // RULE17
	end

	assign irq_a = timer_a_overflow_flag;
	assign irq_b = timer_b_overflow_flag;

	// ********************************
	// Read port
	// ********************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= dtc_pkg::RESET_BYTE;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				dtc_pkg::ADDR_CONTROL_STATUS: reg_rdata <= {timer_b_overflow_flag, timer_b_run,
					timer_a_overflow_flag, timer_a_run, 4'h0};
				dtc_pkg::ADDR_MODE:           reg_rdata <= timer_mode_reg;
				dtc_pkg::ADDR_TICK_SELECT:    reg_rdata <= {2'h0, timer_c_tick_select,
					timer_b_tick_select, timer_a_tick_select, 3'h0};
				dtc_pkg::ADDR_A_LOW:          reg_rdata <= timer_a_low_byte;
				dtc_pkg::ADDR_A_HIGH:         reg_rdata <= timer_a_high_byte;
				dtc_pkg::ADDR_B_LOW:          reg_rdata <= timer_b_low_byte;
				dtc_pkg::ADDR_B_HIGH:         reg_rdata <= timer_b_high_byte;
				default:                      reg_rdata <= dtc_pkg::RESET_BYTE;
			endcase
		end
		else
			reg_rdata <= dtc_pkg::RESET_BYTE;
	end

endmodule

`default_nettype wire

//--- hdl/dtc_pkg.sv
/*
 * Constants for the dual timer/counter block: register offsets, field
 * positions, mode codes and tick timing.
 * Assumes a 20 MHz system clock and a byte-wide register port.
 */
package dtc_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h0;
	localparam logic [2:0] ADDR_MODE           = 3'h1;
	localparam logic [2:0] ADDR_TICK_SELECT    = 3'h2;
	localparam logic [2:0] ADDR_A_LOW          = 3'h3;
	localparam logic [2:0] ADDR_A_HIGH         = 3'h4;
	localparam logic [2:0] ADDR_B_LOW          = 3'h5;
	localparam logic [2:0] ADDR_B_HIGH         = 3'h6;

	// Control/status register bits
	localparam int BIT_B_FLAG = 7;
	localparam int BIT_B_RUN  = 6;
	localparam int BIT_A_FLAG = 5;
	localparam int BIT_A_RUN  = 4;

	// Mode register: timer_a in bits 3..0, timer_b in bits 7..4
	localparam int MODE_B_BASE = 4;
	localparam int FLD_GATE    = 3;
	localparam int FLD_SOURCE  = 2;
	localparam int FLD_MODE_HI = 1;
	localparam int FLD_MODE_LO = 0;

	// Tick select register bits
	localparam int BIT_C_TICK = 5;
	localparam int BIT_B_TICK = 4;
	localparam int BIT_A_TICK = 3;
	localparam logic [7:0] TICK_SELECT_MASK = 8'h38;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hFF;
	localparam logic [4:0] LOW5_ONES  = 5'h1F;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'h0,
		DTC_MODE_16BIT  = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT  = 2'h3
	} dtc_mode_t;

	// Prescaler: one tick every twelve system clocks
	localparam int         PRESCALE_DIV  = 12;
	localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
	localparam logic [3:0] PRESCALE_ZERO = 4'h0;
endpackage

//--- verif/dtc_pins.sv
/*
 * Pin source for the timer bench: falling-edge trains on either count pin.
 * Assumes one start pulse per train, issued only while idle.
 */
`timescale 1ns/1ps
`default_nettype none

module dtc_pins
(
	input  wire logic       clk,         // System clock
	input  wire logic       rst_n,       // Synchronous reset, active low
	input  wire logic       start,       // Begin a train
	input  wire logic       sel,         // 0 pin a, 1 pin b
	input  wire logic [7:0] count,       // Falling edges to make
	output logic            count_pin_a, // Event pin a
	output logic            count_pin_b, // Event pin b
	output logic            busy         // Train in progress
);
	logic [7:0] left;
	logic [1:0] phase;
	logic       level;

	// ****************
	// Pulse train
	// ****************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			left  <= 8'h00;
			phase <= 2'h0;
			level <= 1'b1;
		end
		else if (start)
			left <= count;
		else if (left != 8'h00)
		begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			if (phase == 2'h2)
				level <= !level;
			if (phase == 2'h2 && !level)
				left <= left - 8'h01;
		end
	end

	assign count_pin_a = sel ? 1'b1 : level;
	assign count_pin_b = sel ? level : 1'b1;
	assign busy        = left != 8'h00;
endmodule

`default_nettype wire

//--- verif/dtc_timer_chk.sv
/*
 * Port-level assertions for dtc_timer.
 * Assumes the single clk domain with synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dtc_timer_chk
(
	input wire logic       clk,            // System clock
	input wire logic       rst_n,          // Reset, active low
	input wire logic [2:0] reg_addr,       // Register address
	input wire logic [7:0] reg_wdata,      // Write data
	input wire logic       reg_wr,         // Write strobe
	input wire logic       reg_rd,         // Read strobe
	input wire logic [7:0] reg_rdata,      // Read data
	input wire logic       int_ack_a,      // Vector ack a
	input wire logic       int_ack_b,      // Vector ack b
	input wire logic       irq_a,          // Flag a
	input wire logic       irq_b,          // Flag b
	input wire logic       overflow_b_pulse // Timer_b overflow
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ****************
	// Properties
	// ****************
	chk_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_unmapped_read: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
		else $error("unmapped address returned data");
	chk_tick_mask: assert property (reg_rd && reg_addr == 3'h2 |=> (reg_rdata & 8'hC7) == 8'h00)
		else $error("tick select spare bits not zero");
	chk_flag_read: assert property (reg_rd && reg_addr == 3'h0
		|=> reg_rdata[5] == $past(irq_a) && reg_rdata[7] == $past(irq_b))
		else $error("status flags differ from irq lines");
	chk_reset_clear: assert property ($rose(rst_n)
		|-> !irq_a && !irq_b && !overflow_b_pulse && reg_rdata == 8'h00)
		else $error("outputs not cleared by reset");
	chk_flag_hold_a: assert property (irq_a && !int_ack_a
		&& !(reg_wr && reg_addr == 3'h0 && !reg_wdata[5]) |=> irq_a)
		else $error("flag a dropped without a clear");
	chk_flag_hold_b: assert property (irq_b && !int_ack_b
		&& !(reg_wr && reg_addr == 3'h0 && !reg_wdata[7]) |=> irq_b)
		else $error("flag b dropped without a clear");
	chk_mode_readback: assert property (reg_wr && reg_addr == 3'h1 ##1 reg_rd && reg_addr == 3'h1
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("mode register read back wrong");
endmodule

bind dtc_timer dtc_timer_chk chk
(
	.clk(clk),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.int_ack_a(int_ack_a),
	.int_ack_b(int_ack_b),
	.irq_a(irq_a),
	.irq_b(irq_b),
	.overflow_b_pulse(overflow_b_pulse)
);

`default_nettype wire

//--- verif/dual_timer_counter_four_modes_test.sv
/*
 * Self-checking bench for dtc_timer: registers, modes, gating, pins.
 * Assumes dtc_pins as pin source and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_four_modes_test;
	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic [2:0]  reg_addr  = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [1:0]  ack       = 2'h0;
	logic [1:0]  gate      = 2'h3;
	logic        pstart    = 1'b0;
	logic        psel      = 1'b0;
	logic [7:0]  pn        = 8'h00;
	logic [7:0]  reg_rdata;
	logic        pin_a;
	logic        pin_b;
	logic        busy;
	logic [1:0]  irq;
	logic        ob_pulse;
	logic [31:0] seed      = 32'hFB9764B6;
	int          err_total = 0;
	int          checked   = 0;
	int          pulses    = 0;
	int          p0        = 0;

	always #25 clk = ~clk;

	// Counts timer_b overflow pulses, each seen at one edge
	always @(posedge clk)
		if (ob_pulse === 1'b1)
			pulses++;

	dtc_timer DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin_a(pin_a),
		.count_pin_b(pin_b), .gate_input_a_n(gate[0]), .gate_input_b_n(gate[1]),
		.int_ack_a(ack[0]), .int_ack_b(ack[1]), .irq_a(irq[0]), .irq_b(irq[1]),
		.overflow_b_pulse(ob_pulse));
	dtc_pins pins (.clk(clk), .rst_n(rst_n), .start(pstart), .sel(psel), .count(pn),
		.count_pin_a(pin_a), .count_pin_b(pin_b), .busy(busy));

	// ****************
	// Helpers
	// ****************
	task automatic conclude();
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic logic [16:0] model(input logic [1:0] m, input logic [15:0] v, input int k);
		logic        ovf;
		logic [12:0] n13;
		ovf = 1'b0;
		for (int i = 0; i < k; i++)
		begin
			if (m == 2'h0)
			begin
				n13 = {v[15:8], v[4:0]} + 13'h0001;
				ovf |= (n13 == 13'h0000);
				v = {n13[12:5], v[7:5], n13[4:0]};
			end
			else if (m == 2'h1)
			begin
				v = v + 16'h0001;
				ovf |= (v == 16'h0000);
			end
			else
			begin
				ovf |= (v[7:0] == 8'hFF);
				v[7:0] = (v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h01;
			end
		end
		return {ovf, v};
	endfunction

	task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d,
		input logic [1:0] k);
		reg_wr    <= w;
		reg_rd    <= r;
		reg_addr  <= a;
		reg_wdata <= d;
		ack       <= k;
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00, 2'h0);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d, 2'h0);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		bus(1'b0, 1'b1, a, 8'h00, 2'h0);
		#1;
		check(reg_rdata, exp);
	endtask

	task automatic setup(input int t, input logic [3:0] m, input logic [7:0] tk,
		input logic [7:0] lo, input logic [7:0] hi);
		wr(3'h0, 8'h00);
		wr(3'h1, 8'(m) << (4 * t));
		wr(3'h2, tk);
		wr(3'(3 + 2 * t), lo);
		wr(3'(4 + 2 * t), hi);
	endtask

	// Run for k counting edges, flags written as ones so they stay
	task automatic go(input int t, input int k);
		wr(3'h0, 8'hA0 | (8'h10 << (2 * t)));
		idle(k - 1);
		wr(3'h0, 8'hA0);
	endtask

	task automatic run_timer(input int t, input logic [1:0] m, input logic [31:0] r);
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [16:0] e;
		int          k;
		lo = r[7:0] | 8'hF0;
		hi = (m == 2'h2) ? r[15:8] : 8'hFF;
		k = int'(r[20:16]) + 1;
		e = model(m, {hi, lo}, k);
		setup(t, {2'h0, m}, 8'h08 << t, lo, hi);
		go(t, k);
		rd(3'(3 + 2 * t), e[7:0]);
		rd(3'(4 + 2 * t), e[15:8]);
		rd(3'h0, 8'(e[16]) << (5 + 2 * t));
		check({6'h00, irq}, 8'(e[16]) << t);
		bus(1'b0, 1'b0, 3'h0, 8'h00, 2'(1 << t));
		rd(3'h0, 8'h00);
		check({6'h00, irq}, 8'h00);
	endtask

	// ****************
	// Sequence
	// ****************
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00);
		wr(3'h2, 8'hFF);
		rd(3'h2, 8'h38);
		wr(3'h1, 8'hC5);
		rd(3'h1, 8'hC5);
		for (int t = 0; t < 2; t++)
			for (int i = 0; i < 6; i++)
			begin
				seed = xs(seed);
				run_timer(t, 2'(i % 3), seed);
			end
		setup(0, 4'h1, 8'h00, 8'h00, 8'h00);
		go(0, 120);
		rd(3'h3, 8'h0A);
		for (int t = 0; t < 2; t++)
		begin
			setup(t, 4'h9, 8'h08 << t, 8'h05, 8'h00);
			gate <= 2'h0;
			go(t, 10);
			rd(3'(3 + 2 * t), 8'h05);
			gate <= 2'h3;
			go(t, 10);
			rd(3'(3 + 2 * t), 8'h0F);
		end
		for (int t = 0; t < 2; t++)
		begin
			seed = xs(seed);
			setup(t, 4'h5, 8'h00, 8'h00, 8'h00);
			wr(3'h0, 8'hA0 | (8'h10 << (2 * t)));
			psel   <= t[0];
			pn     <= {5'h00, seed[2:0]} + 8'h01;
			pstart <= 1'b1;
			idle(1);
			pstart <= 1'b0;
			idle(1);
			for (int i = 0; i < 400 && busy; i++)
				idle(1);
			idle(4);
			wr(3'h0, 8'hA0);
			rd(3'(3 + 2 * t), {5'h00, seed[2:0]} + 8'h01);
		end
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h18);
		wr(3'h3, 8'h00);
		wr(3'h4, 8'hFE);
		wr(3'h5, 8'hFF);
		wr(3'h6, 8'hFF);
		p0 = pulses;
		wr(3'h1, 8'h13);
		idle(1);
		rd(3'h0, 8'h00);
		wr(3'h0, 8'hF0);
		idle(2);
		wr(3'h0, 8'hA0);
		rd(3'h3, 8'h03);
		rd(3'h4, 8'h01);
		rd(3'h0, 8'h80);
		check(8'(pulses - p0), 8'h01);
		wr(3'h1, 8'h30);
		wr(3'h5, 8'h42);
		wr(3'h0, 8'hE0);
		idle(5);
		wr(3'h0, 8'hA0);
		rd(3'h5, 8'h42);
		conclude();
	end

	initial
	begin
		#2000000;
		err_total++;
		conclude();
	end
endmodule

`default_nettype wire
